// [src/tdam_direct_adc.sv]
// Direct conversion mode of the optical front end: slot bypass control and ADC sequencing.
// Assumes the timing core gives same-clock sample pulses and the light level arrives asynchronously.
// Notes on behaviour
// [R1] A slot in direct mode sends the amplifier output straight to the ADC, past filter and integrator.
// [R2] Each sample event in direct mode converts four channels in order, 1 us apart; events arriving during a run, and slot B's event on a tie, are dropped.
// [R3] Software selects direct mode for slot A by writing 0xB065 at offset slot_a_filter_bypass.
// [R4] Software selects direct mode for slot B by writing 0xB065 at offset slot_b_filter_bypass.
// [R5] One slot may run in direct mode while the other runs the normal pulsed chain.
// [R6] The output code falls as light rises, since the amplifier inverts.
// [R7] With no input current each sample reads the dark code of about 13000 LSB.
// [R8] A zero photodiode select field for a slot opens the photodiode and gives the baseline.
// [R9] A bypass write touches only its own slot; the other slot keeps its configuration.
`timescale 1ns/1ps
`include "tdam_map.svh"
module tdam_direct_adc
  import tdam_pkg::*;
#(
  parameter int DW = 14
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o,
  input wire logic slot_a_sample_i,
  input wire logic slot_b_sample_i,
  input wire logic chan_group_i,
  input wire logic [DW-1:0] light_i,
  output logic slot_a_bypass_o,
  output logic slot_b_bypass_o,
  output logic adc_conv_o,
  output logic [2:0] adc_chan_o,
  output logic sample_valid_o,
  output logic [DW-1:0] sample_data_o,
  output logic [2:0] sample_chan_o,
  output logic sample_slot_o
);
  localparam int CONV_GAP = `TDAM_CONV_CYCLES;

  logic [15:0] pd_select;
  logic [15:0] a_bypass;
  logic [15:0] b_bypass;
  logic [DW-1:0] light_meta;
  logic [DW-1:0] light_sync;
  logic seq_busy;
  logic seq_conv;
  logic [1:0] seq_ch;
  logic seq_start;
  tdam_slot_t run_slot;
  logic run_group;
  logic pd_open;

  function automatic logic is_direct(input logic [15:0] value);
    is_direct = (value == `TDAM_BYPASS_KEY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register port.

  // [R3] [R4] [R9] Per-slot bypass writes.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pd_select <= `TDAM_PD_SELECT_RST;
      a_bypass <= `TDAM_BYPASS_RST;
      b_bypass <= `TDAM_BYPASS_RST;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `TDAM_ADDR_PD_SELECT: pd_select <= reg_wdata_i;
        `TDAM_ADDR_A_BYPASS: a_bypass <= reg_wdata_i;
        `TDAM_ADDR_B_BYPASS: b_bypass <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Unmapped offsets read as zero.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `TDAM_ADDR_PD_SELECT: reg_rdata_o <= pd_select;
        `TDAM_ADDR_A_BYPASS: reg_rdata_o <= a_bypass;
        `TDAM_ADDR_B_BYPASS: reg_rdata_o <= b_bypass;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // [R1] [R5] Bypass routing per slot.
  assign slot_a_bypass_o = is_direct(a_bypass);
  assign slot_b_bypass_o = is_direct(b_bypass);

  ////////////////////////////////////////////////////////////////////////////////
  // Light level crossing and sequencing.

  // The light level is quasi-static, so a plain two-stage capture is accepted here.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      light_meta <= '0;
      light_sync <= '0;
    end else begin
      light_meta <= light_i;
      light_sync <= light_meta;
    end
  end

  // [R5] Only a slot in direct mode starts the sequencer; slot A wins a tie.
  assign seq_start = !seq_busy && ((slot_a_sample_i && slot_a_bypass_o) ||
                                   (slot_b_sample_i && slot_b_bypass_o));

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      run_slot <= TDAM_SLOT_A;
      run_group <= 1'b0;
    end else if (seq_start) begin
      run_slot <= (slot_a_sample_i && slot_a_bypass_o) ? TDAM_SLOT_A : TDAM_SLOT_B;
      run_group <= chan_group_i;
    end
  end

  // [R2] Four conversions 1 us apart.
  tdam_conv_seq #(
    .GAP(CONV_GAP),
    .NCONV(`TDAM_NUM_CONV)
  ) u_seq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(seq_start),
    .busy_o(seq_busy),
    .conv_o(seq_conv),
    .ch_o(seq_ch)
  );

  assign adc_conv_o = seq_conv;
  assign adc_chan_o = {run_group, seq_ch};

  // [R8] Open photodiode when the active slot's select field is zero.
  assign pd_open = (run_slot == TDAM_SLOT_A) ?
    (pd_select[`TDAM_PD_A_LSB +: `TDAM_PD_WIDTH] == 4'h0) :
    (pd_select[`TDAM_PD_B_LSB +: `TDAM_PD_WIDTH] == 4'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // Result formation.

  // [R6] [R7] Inverting transfer from the dark code, clamped at zero.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sample_valid_o <= 1'b0;
      sample_data_o <= '0;
      sample_chan_o <= 3'h0;
      sample_slot_o <= 1'b0;
    end else begin
      sample_valid_o <= seq_conv;
      if (seq_conv) begin
        sample_chan_o <= {run_group, seq_ch};
        sample_slot_o <= (run_slot == TDAM_SLOT_B);
        if (pd_open || light_sync == '0) begin
          sample_data_o <= `TDAM_DARK_CODE;
        end else if (light_sync >= `TDAM_DARK_CODE) begin
          sample_data_o <= '0;
        end else begin
          sample_data_o <= `TDAM_DARK_CODE - light_sync;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_conv_mid;
    seq_conv && seq_ch != 2'h3;
  endsequence

  a_bypass_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R1]
    reg_we_i && reg_addr_i == `TDAM_ADDR_A_BYPASS && reg_wdata_i == `TDAM_BYPASS_KEY
    |=> slot_a_bypass_o) else $error("slot A bypass not taken");

  a_conv_spacing: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    s_conv_mid |-> ##CONV_GAP seq_conv) else $error("conversion spacing wrong");

  a_conv_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    s_conv_mid |=> !seq_conv [*8]) else $error("conversion came too early");

  a_mixed_slots: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R5]
    seq_start && slot_a_bypass_o && !slot_b_bypass_o && !reg_we_i
    |=> run_slot == TDAM_SLOT_A && !slot_b_bypass_o) else $error("mixed slot run failed");

  a_inverting_out: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R6]
    seq_conv && !pd_open && light_sync != '0 && light_sync < `TDAM_DARK_CODE
    |=> sample_data_o == `TDAM_DARK_CODE - $past(light_sync)) else $error("not inverting");

  a_dark_level: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R7]
    seq_conv && light_sync == '0 |=> sample_valid_o && sample_data_o == `TDAM_DARK_CODE)
    else $error("dark level wrong");

  a_open_baseline: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R8]
    seq_conv && pd_open |=> sample_data_o == `TDAM_DARK_CODE) else $error("open pd not baseline");

  a_slot_isolate: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R9]
    reg_we_i && reg_addr_i == `TDAM_ADDR_A_BYPASS |=> $stable(slot_b_bypass_o))
    else $error("slot B disturbed");

  sequence s_conv_any;
    seq_conv;
  endsequence

  a_bypass_route_b: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R1]
    reg_we_i && reg_addr_i == `TDAM_ADDR_B_BYPASS && reg_wdata_i == `TDAM_BYPASS_KEY
    |=> slot_b_bypass_o) else $error("slot B bypass not taken");

  a_valid_follows: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    s_conv_any |=> sample_valid_o && sample_chan_o == $past(adc_chan_o))
    else $error("sample valid missing");

  a_group_held: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    seq_busy |=> $stable(run_group) && $stable(run_slot)) else $error("run context changed");

  a_start_refused: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R5]
    !seq_busy && !(slot_a_sample_i && slot_a_bypass_o) &&
    !(slot_b_sample_i && slot_b_bypass_o)
    |=> !seq_busy) else $error("sequencer started without a direct slot");
endmodule

// [src/tdam_map.svh]
// Register map, field positions, reset values and timing counts of the direct conversion block.
// Assumes a 125 MHz core clock and a 16-bit register port with 8-bit offsets.
`ifndef TDAM_MAP_SVH
`define TDAM_MAP_SVH

`define TDAM_ADDR_PD_SELECT 8'h14
`define TDAM_ADDR_A_BYPASS 8'h43
`define TDAM_ADDR_B_BYPASS 8'h45
`define TDAM_BYPASS_KEY 16'hB065
`define TDAM_PD_SELECT_RST 16'h0550
`define TDAM_BYPASS_RST 16'h0000
`define TDAM_PD_A_LSB 4
`define TDAM_PD_B_LSB 8
`define TDAM_PD_WIDTH 4
`define TDAM_DARK_CODE 14'h32C8
`define TDAM_CLK_PERIOD_NS 8
`define TDAM_CONV_SPACING_NS 1000
`define TDAM_CONV_CYCLES ((`TDAM_CONV_SPACING_NS + `TDAM_CLK_PERIOD_NS - 1) / `TDAM_CLK_PERIOD_NS)
`define TDAM_NUM_CONV 4

`endif

// [src/tdam_pkg.sv]
// Types shared by the direct conversion block.
// Assumes nothing beyond the map header.
package tdam_pkg;
  typedef enum logic {TDAM_SLOT_A, TDAM_SLOT_B} tdam_slot_t;
  typedef enum logic [0:0] {TDAM_SEQ_IDLE, TDAM_SEQ_RUN} tdam_seq_state_t;
endpackage

// [src/tdam_conv_seq.sv]
// Conversion sequencer: four conversions spaced a fixed number of cycles apart.
// Assumes a single-cycle start pulse from logic on the same clock.
`timescale 1ns/1ps
`include "tdam_map.svh"
module tdam_conv_seq
  import tdam_pkg::*;
#(
  parameter int GAP = `TDAM_CONV_CYCLES,
  parameter int NCONV = `TDAM_NUM_CONV
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  output logic busy_o,
  output logic conv_o,
  output logic [1:0] ch_o
);
  tdam_seq_state_t state;
  logic [7:0] cnt;

  assign busy_o = (state == TDAM_SEQ_RUN);
  assign conv_o = busy_o && (cnt == 8'h00);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= TDAM_SEQ_IDLE;
      cnt <= 8'h00;
      ch_o <= 2'h0;
    end else begin
      case (state)
        TDAM_SEQ_IDLE: begin
          cnt <= 8'h00;
          ch_o <= 2'h0;
          if (start_i) begin
            state <= TDAM_SEQ_RUN;
          end
        end
        TDAM_SEQ_RUN: begin
          if (cnt == 8'(GAP - 1)) begin
            cnt <= 8'h00;
            if (ch_o == 2'(NCONV - 1)) begin
              state <= TDAM_SEQ_IDLE;
              ch_o <= 2'h0;
            end else begin
              ch_o <= ch_o + 2'h1;
            end
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          state <= TDAM_SEQ_IDLE;
        end
      endcase
    end
  end
endmodule

// [verif/tdam_pd_model.sv]
// Photodiode model: turns a light level into the code seen at the block input.
// Assumes the bench sets the level; the current settles off the clock grid.
`timescale 1ns/1ps
module tdam_pd_model (
  input wire logic [13:0] level_i,
  output wire logic [13:0] light_o
);
  // Current always sourced.
  // The block must open the diode itself, so the model never drops the current for it.
  assign #3.3 light_o = level_i;
endmodule

// [verif/tdam_tb.sv]
// Self-checking bench of the direct conversion block with a photodiode model.
// Assumes the map header, package and block sources are compiled first.
`timescale 1ns/1ps
`include "tdam_map.svh"
module tb;
  import tdam_pkg::*;
  localparam int GAP = `TDAM_CONV_CYCLES;
  logic clk_i = 0, rstn_i = 0, we = 0, re = 0, sa = 0, sb = 0, grp = 0, ea = 0, eb = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000, rdat;
  logic [13:0] lvl = 14'h0000, light, sdat;
  logic byp_a, byp_b, conv, vld, sslot;
  logic [2:0] ach, sch;
  int n_fail = 0, n_compared = 0;
  tdam_pd_model PD (.level_i(lvl), .light_o(light));
  tdam_direct_adc DUT (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat), .slot_a_sample_i(sa),
    .slot_b_sample_i(sb), .chan_group_i(grp), .light_i(light), .slot_a_bypass_o(byp_a),
    .slot_b_bypass_o(byp_b), .adc_conv_o(conv), .adc_chan_o(ach), .sample_valid_o(vld),
    .sample_data_o(sdat), .sample_chan_o(sch), .sample_slot_o(sslot));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wd = d;
    we = 1;
    step();
    we = 0;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    addr = a;
    re = 1;
    step();
    re = 0;
    chk("rdata", rdat, e);
    step();
  endtask
  // Dark code minus light, clipped at zero; an open diode reads dark.
  function automatic logic [13:0] dark_exp(input logic [13:0] lv, input logic opn);
    if (opn || lv == 14'h0000) return 14'h32C8;
    return (lv >= 14'h32C8) ? 14'h0000 : 14'h32C8 - lv;
  endfunction
  task automatic run(input logic s, input logic [13:0] lv, input logic opn);
    logic g;
    logic act;
    int k;
    g = 1'($urandom);
    act = s ? eb : ea;
    lvl = lv;
    grp = g;
    repeat (4) step();
    sa = !s;
    sb = s;
    step();
    sa = 0;
    sb = 0;
    // The sequencer stays busy for one spacing after its last conversion.
    for (k = 1; k <= 4 * GAP + 3; k++) begin
      chk("conv", conv, act && (k - 1) % GAP == 0 && k <= 3 * GAP + 1);
      chk("valid", vld, act && k > 1 && (k - 2) % GAP == 0 && k <= 3 * GAP + 2);
      if (conv) chk("adc_chan", ach, {g, 2'((k - 1) / GAP)});
      if (vld) chk("data", sdat, dark_exp(lv, opn));
      if (vld) chk("chan", sch, {g, 2'((k - 2) / GAP)});
      if (vld) chk("slot", sslot, s);
      step();
    end
    $display("run slot %0d level %h done", s, lv);
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(99));
    repeat (3) @(posedge clk_i);
    #1;
    rstn_i = 1;
    rd(8'h14, 16'h0550);
    rd(8'h43, 16'h0000);
    rd(8'h45, 16'h0000);
    rd(8'h20, 16'h0000);
    run(0, 14'h0100, 0);
    $display("test reset done");
    wr(8'h43, 16'hB065);
    ea = 1;
    wr(8'h45, 16'hB064);
    wr(8'h44, 16'hB065);
    chk("byp_a", byp_a, 1);
    chk("byp_b", byp_b, 0);
    rd(8'h43, 16'hB065);
    run(1, 14'h0100, 0);
    run(0, 14'h0000, 0);
    run(0, 14'h32C8, 0);
    run(0, 14'h3FFF, 0);
    $display("test slot A done");
    wr(8'h45, 16'hB065);
    eb = 1;
    chk("byp_b", byp_b, 1);
    repeat (5) run(1'($urandom), 14'($urandom), 0);
    wr(8'h14, 16'h0050);
    rd(8'h14, 16'h0050);
    run(1, 14'h1000, 1);
    run(0, 14'h1000, 0);
    wr(8'h43, 16'h0000);
    ea = 0;
    chk("byp_a", byp_a, 0);
    chk("byp_b", byp_b, 1);
    run(0, 14'h1000, 0);
    $display("test baseline done");
    summarize();
  end
endmodule
